// >>> hdl/wcf_flush_selector.sv
// Write cache flush selector: entry address table, flush policy and the
// AXI4-Lite register slave holding the control and scratchpad registers.
// Assumes alloc/take come from logic on core_clk_i; cache data is elsewhere.
`timescale 1ns/1ns
`default_nettype none
`include "wcf_cfg.svh"

module wcf_flush_selector
  import wcf_pkg::*;
#(
  parameter int N  = 8,
  parameter int IW = $clog2(N)
) (
  input  wire logic          core_clk_i,
  input  wire logic          srst_i,
  // Fill side: a write posted into cache slot alloc_idx_i
  input  wire logic          alloc_i,
  input  wire logic [IW-1:0] alloc_idx_i,
  input  wire waddr_t        alloc_addr_i,
  // Flush side: DRAM controller takes the offered entry
  input  wire logic          take_i,
  output logic               sel_valid_o,
  output logic [IW-1:0]      sel_idx_o,
  output waddr_t             sel_addr_o,
  output logic               sel_spatial_o,
  // AXI4-Lite slave
  input  wire logic [31:0]   s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [31:0]   s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready
);

  // ---------------- register file ----------------
  flush_mode_e  ctrl_mode;
  logic [1:0]   ctrl_mask;   // {bit 13 mask, bit 12 mask}
  logic [15:0]  scratch;
  logic [31:0]  aw_addr;
  logic [31:0]  w_data;
  logic [3:0]   w_strb;

  // Write decode on the held address and data
  wire logic wr_fire    = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire logic wr_ctrl    = aw_addr == `WCF_CTRL_ADDR;
  wire logic wr_scratch = aw_addr == `WCF_SCRATCH_ADDR;
  wire logic rd_ctrl    = s_axi_araddr == `WCF_CTRL_ADDR;
  wire logic rd_scratch = s_axi_araddr == `WCF_SCRATCH_ADDR;
  wire logic ar_fire    = s_axi_arvalid && s_axi_arready;

  // Reserved control bits 7:4 read zero
  wire logic [31:0] rd_mux = rd_ctrl    ? {28'h000_0000, ctrl_mask, ctrl_mode} :
                             rd_scratch ? {16'h0000, scratch} : 32'h0000_0000;

  // Write channels: each ready drops once its beat is held
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_addr       <= 32'h0000_0000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr       <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Response one cycle after both beats are held; unmapped gets SLVERR
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `WCF_RESP_OKAY;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_ctrl || wr_scratch) ? `WCF_RESP_OKAY : `WCF_RESP_SLVERR;
    end
  end

  // Register storage; the scratchpad feeds nothing but the read mux
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ctrl_mode <= flush_mode_e'(2'(`WCF_CTRL_RST));
      ctrl_mask <= 2'(`WCF_CTRL_RST >> `WCF_MASK12_BIT);
      scratch   <= `WCF_SCRATCH_RST;
    end else if (wr_fire) begin
      if (wr_ctrl && w_strb[0]) begin
        ctrl_mode <= flush_mode_e'(w_data[`WCF_MODE_MSB:`WCF_MODE_LSB]);
        ctrl_mask <= {w_data[`WCF_MASK13_BIT], w_data[`WCF_MASK12_BIT]};
      end
      if (wr_scratch && w_strb[0]) begin
        scratch[7:0] <= w_data[7:0];
      end
      if (wr_scratch && w_strb[1]) begin
        scratch[15:8] <= w_data[15:8];
      end
    end
  end

  // Read channel: data one cycle after the address is taken
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `WCF_RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= (rd_ctrl || rd_scratch) ? `WCF_RESP_OKAY : `WCF_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ---------------- entry table ----------------
  logic [N-1:0] valid;
  waddr_t       addr [N];
  waddr_t       last_addr;
  logic         last_valid;
  logic [N-1:0] hit;
  logic [N-1:0] cand;

  wire logic take_ok   = take_i && sel_valid_o;
  wire logic page_mode = ctrl_mode == MODE_PAGE_HIT;
  wire logic row_mode  = ctrl_mode == MODE_ROW_MISS;

  pick_if #(.N(N)) pk ();

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_ent
      wcf_spatial_cmp u_cmp (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .last_i     (last_addr),
        .entry_i    (addr[i]),
        .mask_i     (ctrl_mask),
        .hit_o      (hit[i])
      );
      // No candidates before the first flush or in LRU/reserved mode
      assign cand[i] = last_valid && valid[i] &&
                       ((page_mode && hit[i]) || (row_mode && !hit[i]));

      // Allocation wins over a take of the same slot
      always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
          valid[i] <= 1'b0;
          addr[i]  <= '0;
        end else if (alloc_i && alloc_idx_i == IW'(i)) begin
          valid[i] <= 1'b1;
          addr[i]  <= alloc_addr_i;
        end else if (take_ok && sel_idx_o == IW'(i)) begin
          valid[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign pk.valid     = valid;
  assign pk.cand      = cand;
  assign pk.alloc     = alloc_i;
  assign pk.alloc_idx = alloc_idx_i;

  wcf_lru_pick #(.N(N)) u_pick (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .pk         (pk)
  );

  // Remember the flushed address as the reference for the next search
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      last_addr  <= '0;
      last_valid <= 1'b0;
    end else if (take_ok) begin
      last_addr  <= sel_addr_o;
      last_valid <= 1'b1;
    end
  end

  // Offer is registered; it drops for one cycle after a take so a stale
  // choice is never offered twice
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sel_valid_o   <= 1'b0;
      sel_idx_o     <= '0;
      sel_addr_o    <= '0;
      sel_spatial_o <= 1'b0;
    end else begin
      sel_valid_o   <= pk.found && !take_ok && !alloc_i;
      sel_idx_o     <= pk.idx;
      sel_addr_o    <= addr[pk.idx];
      sel_spatial_o <= pk.from_cand;
    end
  end

  // ---------------- checks ----------------
  wire logic cand_at_pick = cand[pk.idx];
  wire logic quiet        = !take_ok && !alloc_i;

  property p_reset_mode;
    @(posedge core_clk_i) $fell(srst_i) |-> (ctrl_mode == MODE_PAGE_HIT && ctrl_mask == 2'b00);
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("mode not 00 after reset");

  property p_spatial_first;
    @(posedge core_clk_i) disable iff (srst_i)
      (|cand && quiet) |=> (sel_valid_o && sel_spatial_o && $past(cand_at_pick));
  endproperty
  a_spatial_first: assert property (p_spatial_first) else $error("spatial candidate skipped");

  property p_lru_fallback;
    @(posedge core_clk_i) disable iff (srst_i)
      (!(|cand) && |valid && quiet) |=> (sel_valid_o && !sel_spatial_o);
  endproperty
  a_lru_fallback: assert property (p_lru_fallback) else $error("LRU fallback missing");

  property p_page_hit;
    @(posedge core_clk_i) disable iff (srst_i)
      (page_mode && last_valid) |-> (cand == (valid & hit));
  endproperty
  a_page_hit: assert property (p_page_hit) else $error("page hit candidates wrong");

  property p_row_miss;
    @(posedge core_clk_i) disable iff (srst_i)
      (row_mode && last_valid) |-> (cand == (valid & ~hit));
  endproperty
  a_row_miss: assert property (p_row_miss) else $error("row miss candidates wrong");

  property p_lru_mode;
    @(posedge core_clk_i) disable iff (srst_i)
      (!page_mode && !row_mode) |-> (cand == '0);
  endproperty
  a_lru_mode: assert property (p_lru_mode) else $error("spatial active in LRU mode");

  property p_scratch_inert;
    @(posedge core_clk_i) disable iff (srst_i)
      (wr_fire && wr_scratch) |=> ($stable(ctrl_mode) && $stable(ctrl_mask)
                                   && $stable(sel_spatial_o));
  endproperty
  a_scratch_inert: assert property (p_scratch_inert) else $error("scratchpad had an effect");

  property p_read_lat;
    @(posedge core_clk_i) disable iff (srst_i)
      ar_fire |=> (s_axi_rvalid && !s_axi_arready);
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("read data not next cycle");

  c_spatial: cover property (@(posedge core_clk_i) disable iff (srst_i)
                             take_ok && sel_spatial_o);
  c_lru:     cover property (@(posedge core_clk_i) disable iff (srst_i)
                             take_ok && !sel_spatial_o && last_valid);
  c_rowmiss: cover property (@(posedge core_clk_i) disable iff (srst_i)
                             row_mode && |cand);
  c_write:   cover property (@(posedge core_clk_i) disable iff (srst_i)
                             wr_fire && wr_ctrl);

endmodule

`default_nettype wire

// >>> hdl/wcf_cfg.svh
// Constants of the write cache flush selector: offsets, fields, resets.
// Assumes inclusion by bare name from the design files.
`ifndef WCF_CFG_SVH
`define WCF_CFG_SVH

// Register indices; byte address is four times the index
`define WCF_CTRL_IDX      30'h0000_00dc
`define WCF_SCRATCH_IDX   30'h0000_00de
`define WCF_CTRL_ADDR     {`WCF_CTRL_IDX, 2'b00}
`define WCF_SCRATCH_ADDR  {`WCF_SCRATCH_IDX, 2'b00}

// Control register fields
`define WCF_MODE_LSB      0
`define WCF_MODE_MSB      1
`define WCF_MASK12_BIT    2
`define WCF_MASK13_BIT    3

// Reset values
`define WCF_CTRL_RST      8'h00
`define WCF_SCRATCH_RST   16'h0000

// Write address top bit, and lowest bit that is always compared
`define WCF_ADDR_MSB      33
`define WCF_CMP_LSB       14

// Bus responses
`define WCF_RESP_OKAY     2'h0
`define WCF_RESP_SLVERR   2'h2

`endif

// >>> hdl/wcf_pkg.sv
// Types shared by the write cache flush selector modules.
// Assumes wcf_cfg.svh is present on the include path.
`default_nettype none
`include "wcf_cfg.svh"

package wcf_pkg;

  // Flush policy, in field encoding order
  typedef enum logic [1:0] {
    MODE_PAGE_HIT,
    MODE_ROW_MISS,
    MODE_RESERVED,
    MODE_LRU_ONLY
  } flush_mode_e;

  typedef logic [`WCF_ADDR_MSB:0] waddr_t;

endpackage

`default_nettype wire

// >>> hdl/pick_if.sv
// Carrier between the entry table and the age ordering picker.
// Assumes one clock; all members are driven on that clock.
`timescale 1ns/1ns
`default_nettype none

interface pick_if #(
  parameter int N = 8
);
  localparam int IW = $clog2(N);

  logic [N-1:0]  valid;
  logic [N-1:0]  cand;
  logic          alloc;
  logic [IW-1:0] alloc_idx;
  logic [IW-1:0] idx;
  logic          found;
  logic          from_cand;

  modport picker (input valid, cand, alloc, alloc_idx, output idx, found, from_cand);
  modport owner  (output valid, cand, alloc, alloc_idx, input idx, found, from_cand);
endinterface

`default_nettype wire

// >>> hdl/wcf_spatial_cmp.sv
// Masked compare of one cached write address against the last flushed one.
// Assumes both addresses are stable registers on core_clk_i.
`timescale 1ns/1ns
`default_nettype none

module wcf_spatial_cmp
  import wcf_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       srst_i,
  input  wire waddr_t     last_i,
  input  wire waddr_t     entry_i,
  input  wire logic [1:0] mask_i,
  output logic            hit_o
);

  // Bits 33..14 always compared; 13 and 12 only while unmasked
  wire logic upper_eq = last_i[`WCF_ADDR_MSB:`WCF_CMP_LSB]
                        == entry_i[`WCF_ADDR_MSB:`WCF_CMP_LSB];
  wire logic b13_eq   = mask_i[1] || (last_i[13] == entry_i[13]);
  wire logic b12_eq   = mask_i[0] || (last_i[12] == entry_i[12]);
  // A masked bit reads as equal, so it can neither make a miss nor spoil a hit
  assign hit_o = upper_eq && b13_eq && b12_eq;

  property p_upper;
    @(posedge core_clk_i) disable iff (srst_i)
      (last_i[31:16] != entry_i[31:16]) |-> !hit_o;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits differ yet hit");

  property p_b13;
    @(posedge core_clk_i) disable iff (srst_i)
      (last_i[13] != entry_i[13]) |-> (hit_o == (mask_i[1] && upper_eq && b12_eq));
  endproperty
  a_b13: assert property (p_b13) else $error("bit 13 mask misapplied");

  property p_b12;
    @(posedge core_clk_i) disable iff (srst_i)
      (last_i[12] != entry_i[12]) |-> (hit_o == (mask_i[0] && upper_eq && b13_eq));
  endproperty
  a_b12: assert property (p_b12) else $error("bit 12 mask misapplied");

  property p_masked_only;
    @(posedge core_clk_i) disable iff (srst_i)
      (mask_i == 2'b11 && last_i[`WCF_ADDR_MSB:`WCF_CMP_LSB]
       == entry_i[`WCF_ADDR_MSB:`WCF_CMP_LSB]) |-> hit_o;
  endproperty
  a_masked_only: assert property (p_masked_only) else $error("masked bits changed result");

endmodule

`default_nettype wire

// >>> hdl/wcf_lru_pick.sv
// Age ordering of cache entries and pick of the oldest in a candidate set.
// Assumes the table clears valid itself; a freed slot keeps stale age bits.
`timescale 1ns/1ns
`default_nettype none

module wcf_lru_pick #(
  parameter int N = 8
) (
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  pick_if.picker    pk
);
  localparam int IW = $clog2(N);

  // older[j][i] set means entry j was written before entry i
  logic [N-1:0] older [N];
  logic [N-1:0] pool;
  logic [N-1:0] win;
  logic [N-1:0] col [N];

  // Spatial candidates first, otherwise every valid entry
  assign pk.from_cand = |(pk.cand & pk.valid);
  assign pool = pk.from_cand ? (pk.cand & pk.valid) : pk.valid;
  assign pk.found = |pool;

  genvar i, j;
  generate
    for (i = 0; i < N; i++) begin : g_row
      for (j = 0; j < N; j++) begin : g_col
        assign col[i][j] = older[j][i];
        // New write becomes youngest: all others older than it
        always_ff @(posedge core_clk_i) begin
          if (srst_i) begin
            older[i][j] <= 1'b0;
          end else if (pk.alloc && pk.alloc_idx == IW'(i)) begin
            older[i][j] <= 1'b0;
          end else if (pk.alloc && pk.alloc_idx == IW'(j)) begin
            older[i][j] <= 1'b1;
          end
        end
      end
      // Winner has nobody older than itself in the pool
      assign win[i] = pool[i] && !(|(pool & col[i]));
    end
  endgenerate

  // Encode the single winner to an index
  always_comb begin
    pk.idx = '0;
    for (int k = 0; k < N; k++) begin
      if (win[k]) begin
        pk.idx = IW'(k);
      end
    end
  end

  property p_oldest;
    @(posedge core_clk_i) disable iff (srst_i)
      pk.found |-> (pool[pk.idx] && !(|(pool & col[pk.idx])));
  endproperty
  a_oldest: assert property (p_oldest) else $error("pick is not the oldest in pool");

endmodule

`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the write cache flush selector: registers and flush order.
// Assumes the design files, wcf_pkg and wcf_cfg.svh are compiled before this file.
`timescale 1ns/1ns
`default_nettype none
`include "wcf_cfg.svh"

module testbench
  import wcf_pkg::*;
;
  // Slots are filled out of index order so that age and index never coincide
  localparam logic [2:0] SLOT [4]    = '{3'd5, 3'd2, 3'd7, 3'd1};
  localparam waddr_t     BASE        = 34'h1_2345_8000;
  // Masks stick to the legal page-size settings 00, 01 and 11; 10 is never written
  localparam logic [7:0] PH_CTRL [4] = '{8'h00, 8'h04, 8'h0c, 8'h0c};
  localparam waddr_t     PH_D1 [4]   = '{34'h0_0000_4000, 34'h0_0000_2000,
                                         34'h2_0000_0000, 34'h0_0001_0000};
  localparam waddr_t     PH_D2 [4]   = '{34'h0_0000_0010, 34'h0_0000_1000,
                                         34'h0_0000_1000, 34'h0_0000_3000};

  logic        core_clk_i    = 1'b0;
  logic        srst_i        = 1'b1;
  logic        alloc_i       = 1'b0;
  logic [2:0]  alloc_idx_i   = 3'h0;
  waddr_t      alloc_addr_i  = '0;
  logic        take_i        = 1'b0;
  logic        sel_valid_o;
  logic [2:0]  sel_idx_o;
  waddr_t      sel_addr_o;
  logic        sel_spatial_o;
  logic [31:0] s_axi_awaddr  = 32'h0000_0000;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata   = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb   = 4'h0;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready  = 1'b0;
  logic [31:0] s_axi_araddr  = 32'h0000_0000;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready  = 1'b0;
  int          n_mismatch    = 0;
  int          num_checks    = 0;

  wcf_flush_selector #(.N(8)) dut_u (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .alloc_i(alloc_i), .alloc_idx_i(alloc_idx_i),
    .alloc_addr_i(alloc_addr_i), .take_i(take_i), .sel_valid_o(sel_valid_o),
    .sel_idx_o(sel_idx_o), .sel_addr_o(sel_addr_o), .sel_spatial_o(sel_spatial_o),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  // 20 MHz clock
  always #25 core_clk_i = ~core_clk_i;

  // Case equality so that an unknown never passes
  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge core_clk_i);
    srst_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    srst_i <= 1'b0;
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    bit aw_done;
    bit w_done;
    int t;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge core_clk_i);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge core_clk_i);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    chk(s_axi_bvalid, 1'b1, "bvalid");
    chk(s_axi_bresp, er, "bresp");
  endtask

  task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    int t;
    @(posedge core_clk_i);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge core_clk_i);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    chk(s_axi_rvalid, 1'b1, "rvalid");
    chk(s_axi_rdata, ed, "rdata");
    chk(s_axi_rresp, er, "rresp");
  endtask

  // Fill four slots back to back, then take them all, checking each offer
  task automatic run_flush(input logic [7:0] ctrl, input waddr_t d1, input waddr_t d2,
                           input waddr_t d3, input logic [7:0] ord, input logic [3:0] sp);
    waddr_t     ad [4];
    logic [1:0] p;
    int         i;
    int         t;
    ad = '{BASE, BASE ^ d1, BASE ^ d2, BASE ^ d3};
    do_reset();
    axi_wr(`WCF_CTRL_ADDR, {24'h00_0000, ctrl}, 4'h1, `WCF_RESP_OKAY);
    for (i = 0; i < 4; i++) begin
      @(posedge core_clk_i);
      alloc_i      <= 1'b1;
      alloc_idx_i  <= SLOT[i];
      alloc_addr_i <= ad[i];
    end
    @(posedge core_clk_i);
    alloc_i <= 1'b0;
    // Margin so the offer reflects the whole table
    repeat (3) @(posedge core_clk_i);
    for (i = 0; i < 4; i++) begin
      p = ord[2*i +: 2];
      t = 0;
      do begin
        @(negedge core_clk_i);
        t++;
      end while (sel_valid_o !== 1'b1 && t < 40);
      chk(sel_valid_o, 1'b1, "offer");
      chk(sel_idx_o, SLOT[p], "slot");
      chk(sel_addr_o, ad[p], "address");
      chk(sel_spatial_o, sp[i], "spatial flag");
      @(posedge core_clk_i);
      take_i <= 1'b1;
      @(posedge core_clk_i);
      take_i <= 1'b0;
    end
  endtask

  task automatic t_regs();
    axi_rd(`WCF_CTRL_ADDR, 32'h0000_0000, `WCF_RESP_OKAY);
    axi_rd(`WCF_SCRATCH_ADDR, 32'h0000_0000, `WCF_RESP_OKAY);
    axi_wr(`WCF_CTRL_ADDR, 32'hffff_ffff, 4'hf, `WCF_RESP_OKAY);
    axi_rd(`WCF_CTRL_ADDR, 32'h0000_000f, `WCF_RESP_OKAY);
    axi_wr(`WCF_SCRATCH_ADDR, 32'habcd_5678, 4'hf, `WCF_RESP_OKAY);
    axi_wr(`WCF_SCRATCH_ADDR, 32'h0000_11ee, 4'h1, `WCF_RESP_OKAY);
    axi_rd(`WCF_SCRATCH_ADDR, 32'h0000_56ee, `WCF_RESP_OKAY);
    axi_rd(`WCF_CTRL_ADDR, 32'h0000_000f, `WCF_RESP_OKAY);
    axi_wr(32'h0000_0374, 32'h0000_0001, 4'hf, `WCF_RESP_SLVERR);
    axi_rd(32'h0000_0374, 32'h0000_0000, `WCF_RESP_SLVERR);
    $display("test regs done");
  endtask

  // Entries that would match in page-hit mode still leave in age order
  task automatic t_lru();
    run_flush(8'h03, 34'h0_0000_4000, 34'h0_0000_0010, 34'h0_0000_0010, 8'he4, 4'h0);
    run_flush(8'h02, 34'h0_0000_4000, 34'h0_0000_0010, 34'h0_0000_0010, 8'he4, 4'h0);
    $display("test lru done");
  endtask

  // One near miss on a compared bit, two hits differing only in masked or low bits
  task automatic t_page_hit();
    int r;
    for (r = 0; r < 4; r++) begin
      run_flush(PH_CTRL[r], PH_D1[r], PH_D2[r], PH_D2[r], 8'h78, 4'h6);
    end
    $display("test page hit done");
  endtask

  task automatic t_row_miss();
    run_flush(8'h01, 34'h0_0000_0040, 34'h0_0001_0000, 34'h2_0000_0000, 8'hd8, 4'he);
    run_flush(8'h0d, 34'h0_0000_3000, 34'h0_0001_0000, 34'h0_0000_2000, 8'hd8, 4'h6);
    $display("test row miss done");
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    repeat (4) @(posedge core_clk_i);
    srst_i <= 1'b0;
    t_regs();
    t_lru();
    t_page_hit();
    t_row_miss();
    conclude();
  end
endmodule

`default_nettype wire
